/* rtl/lpio_pkg.sv */
package lpio_pkg;

    // ------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------
    localparam int PINS = 22;
    localparam int TOUCH_PADS = 15;
    localparam int PIN_LSB = 10;
    localparam int ADDR_W = 9;
    localparam int SEL_W = 5;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFF_OUT = 9'h000;
    localparam logic [ADDR_W-1:0] OFF_OUT_SET = 9'h004;
    localparam logic [ADDR_W-1:0] OFF_OUT_CLR = 9'h008;
    localparam logic [ADDR_W-1:0] OFF_OE = 9'h00c;
    localparam logic [ADDR_W-1:0] OFF_OE_SET = 9'h010;
    localparam logic [ADDR_W-1:0] OFF_OE_CLR = 9'h014;
    localparam logic [ADDR_W-1:0] OFF_PEND = 9'h018;
    localparam logic [ADDR_W-1:0] OFF_PEND_SET = 9'h01c;
    localparam logic [ADDR_W-1:0] OFF_PEND_CLR = 9'h020;
    localparam logic [ADDR_W-1:0] OFF_IN = 9'h024;
    localparam logic [ADDR_W-1:0] OFF_PINCFG = 9'h028;
    localparam logic [ADDR_W-1:0] OFF_PADCFG = 9'h084;
    localparam logic [ADDR_W-1:0] OFF_XTL = 9'h0e0;
    localparam logic [ADDR_W-1:0] OFF_I2C = 9'h0e4;
    localparam logic [ADDR_W-1:0] OFF_VER = 9'h1fc;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int B_OD = 2;
    localparam int B_ITYPE = 7;
    localparam int B_WAKE = 10;
    localparam int B_FUN_IE = 13;
    localparam int B_SLP_OE = 14;
    localparam int B_SLP_IE = 15;
    localparam int B_SLP_SEL = 16;
    localparam int B_MUX = 19;
    localparam int B_TIE = 23;
    localparam int B_RDE = 27;
    localparam int B_RUE = 28;
    localparam int B_XSEL = 27;
    localparam int B_SCL = 0;
    localparam int B_SDA = 1;

    // interrupt trigger codes
    localparam logic [2:0] IT_OFF = 3'h0;
    localparam logic [2:0] IT_RISE = 3'h1;
    localparam logic [2:0] IT_FALL = 3'h2;
    localparam logic [2:0] IT_ANY = 3'h3;
    localparam logic [2:0] IT_LOW = 3'h4;
    localparam logic [2:0] IT_HIGH = 3'h5;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic {BUS_IDLE, BUS_ANSWER} lpio_bus_t;

    typedef struct packed {
        logic read;
        logic write;
        logic [ADDR_W-1:0] address;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } lpio_avm_req_t;

    typedef struct packed {
        logic light_sleep_wake_enable;
        logic [2:0] irq_trigger_type;
        logic open_drain_select;
    } lpio_pincfg_t;

    typedef struct packed {
        logic pad_pullup_enable;
        logic pad_pulldown_enable;
        logic touch_tie_level;
        logic pad_domain_select;
        logic pad_sleep_override;
        logic pad_sleep_input_enable;
        logic pad_sleep_drive_enable;
        logic pad_input_enable;
    } lpio_padcfg_t;

endpackage

/* rtl/lpio_port.sv */
`timescale 1ns/1ps
// Behaviour
// RULE1 - pin k sits at vector bit 10+k
// RULE2 - output set alias sets output bits
// RULE3 - output clear alias clears output bits
// RULE4 - pin drives only while its enable is set; i2c drive-low drives low-power pins 0-3 low with it clear
// RULE5 - enable set alias sets enable bits
// RULE6 - enable clear alias clears enable bits
// RULE7 - one readable, writable pending bit per pin
// RULE8 - pending set alias forces pending bits
// RULE9 - pending clear alias clears pending bits
// RULE10 - input vector reads current pin levels
// RULE11 - trigger codes: off, rise, fall, any, low, high
// RULE12 - open-drain select makes pin drive low only
// RULE13 - wake enable wakes from light sleep only
// RULE14 - sleep override applies sleep enables while asleep
// RULE15 - domain select: 1 low-power, 0 digital
// RULE16 - pull-up and pull-down bits drive pad pulls
// RULE17 - crystal power-down is chosen pin XOR invert
// RULE18 - i2c clock pin 0/2, data pin 1/3
// RULE19 - touch tie level follows its bit
// RULE20 - software leaves touch source select at zero
// RULE21 - trigger condition sets pending until cleared
// RULE22 - zeros written to aliases change nothing
module lpio_port #(
    parameter logic [31:0] VERSION_RESET = 32'h0000_0001
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // avalon-mm slave
    input wire lpio_pkg::lpio_avm_req_t avs_req_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // pads
    input wire logic [lpio_pkg::PINS-1:0] pad_in_i,
    output logic [lpio_pkg::PINS-1:0] pad_out_o,
    output logic [lpio_pkg::PINS-1:0] pad_oe_n_o,
    output logic [lpio_pkg::PINS-1:0] pad_ie_o,
    output logic [lpio_pkg::PINS-1:0] pad_pullup_o,
    output logic [lpio_pkg::PINS-1:0] pad_pulldown_o,
    output logic [lpio_pkg::TOUCH_PADS-1:0] touch_tie_o,
    // digital-domain pad logic
    input wire logic [lpio_pkg::PINS-1:0] dig_out_i,
    input wire logic [lpio_pkg::PINS-1:0] dig_oe_i,
    // power state
    input wire logic sleep_i,
    input wire logic light_sleep_i,
    output logic wake_o,
    // crystal power-down
    input wire logic xtal_invert_i,
    output logic xtal_powerdown_o,
    // low-power i2c, open-drain style
    input wire logic i2c_scl_drive_low_i,
    input wire logic i2c_sda_drive_low_i,
    output logic i2c_scl_in_o,
    output logic i2c_sda_in_o
);

    localparam int N = lpio_pkg::PINS;
    localparam int L = lpio_pkg::PIN_LSB;
    localparam logic [6:0] PIN_COUNT = 7'(lpio_pkg::PINS);

    typedef struct packed {
        lpio_pkg::lpio_bus_t bus;
        logic [31:0] rdata;
        logic [N-1:0] out;
        logic [N-1:0] oe;
        logic [N-1:0] pend;
        logic [N-1:0] prev_in;
        lpio_pkg::lpio_pincfg_t [N-1:0] pincfg;
        lpio_pkg::lpio_padcfg_t [N-1:0] padcfg;
        logic [lpio_pkg::SEL_W-1:0] xsel;
        logic scl_route;
        logic sda_route;
        logic [31:0] version;
        logic [N-1:0] pad_out;
        logic [N-1:0] pad_oe_n;
        logic wake;
        logic xtal_pd;
        logic scl_in;
        logic sda_in;
    } lpio_state_t;

    lpio_state_t q;
    lpio_state_t next_q;

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    logic req;
    logic take;
    logic wr_take;
    logic [31:0] wmask;
    logic [N-1:0] wpins;
    logic [N-1:0] wmpins;
    logic [lpio_pkg::ADDR_W-1:0] pin_off;
    logic [lpio_pkg::ADDR_W-1:0] pad_off;
    logic [6:0] pin_idx;
    logic [6:0] pad_idx;
    logic pin_hit;
    logic pad_hit;
    logic [31:0] rd_mux;
    logic [31:0] xtl_new;
    logic [31:0] pin_new;

    assign req = avs_req_i.read | avs_req_i.write;
    assign take = req && (q.bus == lpio_pkg::BUS_ANSWER);
    assign wr_take = take && avs_req_i.write;
    assign avs_waitrequest_o = req && (q.bus == lpio_pkg::BUS_IDLE);
    assign avs_readdata_o = q.rdata;

    always_comb begin
        for (int b = 0; b < 4; b++) begin
            wmask[8*b +: 8] = {8{avs_req_i.byteenable[b]}};
        end
    end

    assign wmpins = wmask[L +: N];
    assign wpins = avs_req_i.writedata[L +: N] & wmpins;
    assign pin_off = avs_req_i.address - lpio_pkg::OFF_PINCFG;
    assign pad_off = avs_req_i.address - lpio_pkg::OFF_PADCFG;
    assign pin_idx = pin_off[8:2];
    assign pad_idx = pad_off[8:2];
    assign pin_hit = (avs_req_i.address >= lpio_pkg::OFF_PINCFG) && (pin_idx < PIN_COUNT);
    assign pad_hit = (avs_req_i.address >= lpio_pkg::OFF_PADCFG) && (pad_idx < PIN_COUNT);

    function automatic logic [31:0] pin_word(input lpio_pkg::lpio_pincfg_t c);
        logic [31:0] w;
        w = '0;
        w[lpio_pkg::B_OD] = c.open_drain_select;
        w[lpio_pkg::B_ITYPE +: 3] = c.irq_trigger_type;
        w[lpio_pkg::B_WAKE] = c.light_sleep_wake_enable;
        return w;
    endfunction

    function automatic logic [31:0] pad_word(input lpio_pkg::lpio_padcfg_t c);
        logic [31:0] w;
        w = '0;
        w[lpio_pkg::B_FUN_IE] = c.pad_input_enable;
        w[lpio_pkg::B_SLP_OE] = c.pad_sleep_drive_enable;
        w[lpio_pkg::B_SLP_IE] = c.pad_sleep_input_enable;
        w[lpio_pkg::B_SLP_SEL] = c.pad_sleep_override;
        w[lpio_pkg::B_MUX] = c.pad_domain_select;
        w[lpio_pkg::B_TIE] = c.touch_tie_level;
        w[lpio_pkg::B_RDE] = c.pad_pulldown_enable;
        w[lpio_pkg::B_RUE] = c.pad_pullup_enable;
        return w;
    endfunction

    // write with byte lanes; the input word is masked here by the lane mask
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [31:0] m);
        return (old & ~m) | (wd & m);
    endfunction

    assign xtl_new = merge({27'h0, q.xsel} << lpio_pkg::B_XSEL, avs_req_i.writedata, wmask);
    assign pin_new = merge(pin_word(q.pincfg[pin_idx[4:0]]), avs_req_i.writedata, wmask);

    // aliases and unmapped offsets read as zero
    always_comb begin
        rd_mux = '0;
        unique case (avs_req_i.address)
            lpio_pkg::OFF_OUT: rd_mux[L +: N] = q.out; // [RULE1]
            lpio_pkg::OFF_OE: rd_mux[L +: N] = q.oe;
            lpio_pkg::OFF_PEND: rd_mux[L +: N] = q.pend; // [RULE7]
            lpio_pkg::OFF_IN: rd_mux[L +: N] = pad_in_i; // [RULE10]
            lpio_pkg::OFF_XTL: rd_mux[lpio_pkg::B_XSEL +: lpio_pkg::SEL_W] = q.xsel;
            lpio_pkg::OFF_I2C: begin
                rd_mux[lpio_pkg::B_SCL] = q.scl_route;
                rd_mux[lpio_pkg::B_SDA] = q.sda_route;
            end
            lpio_pkg::OFF_VER: rd_mux = q.version;
            default: begin
                if (pin_hit && (avs_req_i.address < lpio_pkg::OFF_PADCFG)) begin
                    rd_mux = pin_word(q.pincfg[pin_idx[4:0]]);
                end else if (pad_hit) begin
                    rd_mux = pad_word(q.padcfg[pad_idx[4:0]]);
                end
            end
        endcase
    end

    // ------------------------------------------------------------
    // per-pin trigger detect and pad drive
    // ------------------------------------------------------------
    logic [N-1:0] hit;
    logic [N-1:0] pad_en;
    logic [N-1:0] pad_val;
    logic [N-1:0] sleep_ovr;
    logic [N-1:0] lp_dom;
    logic [N-1:0] i2c_low;

    for (genvar k = 0; k < N; k++) begin : g_pin
        lpio_pkg::lpio_pincfg_t c;
        lpio_pkg::lpio_padcfg_t p;
        logic lp_en;
        logic lp_val;
        logic normal_en;
        logic hk;
        assign c = q.pincfg[k];
        assign p = q.padcfg[k];

        always_comb begin
            unique case (c.irq_trigger_type) // [RULE11]
                lpio_pkg::IT_RISE: hk = pad_in_i[k] & ~q.prev_in[k];
                lpio_pkg::IT_FALL: hk = ~pad_in_i[k] & q.prev_in[k];
                lpio_pkg::IT_ANY: hk = pad_in_i[k] ^ q.prev_in[k];
                lpio_pkg::IT_LOW: hk = ~pad_in_i[k];
                lpio_pkg::IT_HIGH: hk = pad_in_i[k];
                default: hk = 1'b0;
            endcase
        end
        assign hit[k] = hk;

        // i2c lines pull low only, so they override the port's own value
        if (k == 0 || k == 2) begin : g_scl
            assign i2c_low[k] = i2c_scl_drive_low_i && (q.scl_route == (k == 2)); // [RULE18]
        end else if (k == 1 || k == 3) begin : g_sda
            assign i2c_low[k] = i2c_sda_drive_low_i && (q.sda_route == (k == 3)); // [RULE18]
        end else begin : g_none
            assign i2c_low[k] = 1'b0;
        end

        assign sleep_ovr[k] = p.pad_sleep_override & sleep_i; // [RULE14]
        assign lp_dom[k] = p.pad_domain_select; // [RULE15]
        // open drain releases the pad instead of driving high
        assign lp_en = (q.oe[k] & (~c.open_drain_select | ~q.out[k])) | i2c_low[k]; // [RULE12]
        assign lp_val = q.out[k] & ~c.open_drain_select & ~i2c_low[k]; // [RULE12]
        assign normal_en = lp_dom[k] ? lp_en : dig_oe_i[k]; // [RULE15]
        assign pad_en[k] = sleep_ovr[k] ? p.pad_sleep_drive_enable : normal_en; // [RULE14]
        assign pad_val[k] = lp_dom[k] ? lp_val : dig_out_i[k];
        assign pad_ie_o[k] = sleep_ovr[k] ? p.pad_sleep_input_enable : p.pad_input_enable;
        assign pad_pullup_o[k] = p.pad_pullup_enable; // [RULE16]
        assign pad_pulldown_o[k] = p.pad_pulldown_enable; // [RULE16]
        if (k < lpio_pkg::TOUCH_PADS) begin : g_touch
            assign touch_tie_o[k] = p.touch_tie_level; // [RULE19]
        end
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    logic [N-1:0] wake_mask;

    always_comb begin
        for (int k = 0; k < N; k++) begin
            wake_mask[k] = q.pincfg[k].light_sleep_wake_enable;
        end
    end

    always_comb begin
        next_q = q;
        next_q.prev_in = pad_in_i;
        unique case (q.bus)
            lpio_pkg::BUS_IDLE: begin
                if (req) begin
                    next_q.bus = lpio_pkg::BUS_ANSWER;
                    if (avs_req_i.read) begin
                        next_q.rdata = rd_mux;
                    end
                end
            end
            lpio_pkg::BUS_ANSWER: next_q.bus = lpio_pkg::BUS_IDLE;
        endcase

        if (wr_take) begin
            unique case (avs_req_i.address)
                lpio_pkg::OFF_OUT: next_q.out = (q.out & ~wmpins) | wpins;
                lpio_pkg::OFF_OUT_SET: next_q.out = q.out | wpins; // [RULE2] [RULE22]
                lpio_pkg::OFF_OUT_CLR: next_q.out = q.out & ~wpins; // [RULE3] [RULE22]
                lpio_pkg::OFF_OE: next_q.oe = (q.oe & ~wmpins) | wpins;
                lpio_pkg::OFF_OE_SET: next_q.oe = q.oe | wpins; // [RULE5] [RULE22]
                lpio_pkg::OFF_OE_CLR: next_q.oe = q.oe & ~wpins; // [RULE6] [RULE22]
                lpio_pkg::OFF_PEND: next_q.pend = (q.pend & ~wmpins) | wpins; // [RULE7]
                lpio_pkg::OFF_PEND_SET: next_q.pend = q.pend | wpins; // [RULE8] [RULE22]
                lpio_pkg::OFF_PEND_CLR: next_q.pend = q.pend & ~wpins; // [RULE9] [RULE22]
                lpio_pkg::OFF_XTL: next_q.xsel = xtl_new[lpio_pkg::B_XSEL +: lpio_pkg::SEL_W];
                lpio_pkg::OFF_I2C: begin
                    if (avs_req_i.byteenable[0]) begin
                        next_q.scl_route = avs_req_i.writedata[lpio_pkg::B_SCL];
                        next_q.sda_route = avs_req_i.writedata[lpio_pkg::B_SDA];
                    end
                end
                lpio_pkg::OFF_VER: next_q.version = merge(q.version, avs_req_i.writedata, wmask);
                default: begin
                    if (pin_hit && (avs_req_i.address < lpio_pkg::OFF_PADCFG)) begin
                        next_q.pincfg[pin_idx[4:0]] = lpio_pkg::lpio_pincfg_t'({
                            pin_new[lpio_pkg::B_WAKE], pin_new[lpio_pkg::B_ITYPE +: 3],
                            pin_new[lpio_pkg::B_OD]});
                    end else if (pad_hit) begin
                        next_q.padcfg[pad_idx[4:0]] = lpio_pkg::lpio_padcfg_t'({
                            avs_req_i.writedata[lpio_pkg::B_RUE],
                            avs_req_i.writedata[lpio_pkg::B_RDE],
                            avs_req_i.writedata[lpio_pkg::B_TIE],
                            avs_req_i.writedata[lpio_pkg::B_MUX],
                            avs_req_i.writedata[lpio_pkg::B_SLP_SEL],
                            avs_req_i.writedata[lpio_pkg::B_SLP_IE],
                            avs_req_i.writedata[lpio_pkg::B_SLP_OE],
                            avs_req_i.writedata[lpio_pkg::B_FUN_IE]});
                    end
                end
            endcase
        end

        // hardware set wins over any software clear in the same cycle
        next_q.pend = next_q.pend | hit; // [RULE21]
        next_q.pad_out = pad_val;
        next_q.pad_oe_n = ~pad_en; // [RULE4]
        next_q.wake = light_sleep_i & |(hit & wake_mask); // [RULE13]
        next_q.xtal_pd = pad_in_i[q.xsel] ^ xtal_invert_i; // [RULE17]
        next_q.scl_in = q.scl_route ? pad_in_i[2] : pad_in_i[0]; // [RULE18]
        next_q.sda_in = q.sda_route ? pad_in_i[3] : pad_in_i[1]; // [RULE18]
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q <= '0;
            q.bus <= lpio_pkg::BUS_IDLE;
            q.version <= VERSION_RESET;
            q.pad_oe_n <= '1;
        end else begin
            q <= next_q;
        end
    end

    assign pad_out_o = q.pad_out;
    assign pad_oe_n_o = q.pad_oe_n;
    assign wake_o = q.wake;
    assign xtal_powerdown_o = q.xtal_pd;
    assign i2c_scl_in_o = q.scl_in;
    assign i2c_sda_in_o = q.sda_in;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_wr(logic [lpio_pkg::ADDR_W-1:0] a);
        wr_take && (avs_req_i.address == a);
    endsequence

    property p_out_set;
        s_wr(lpio_pkg::OFF_OUT_SET) |=> (q.out == ($past(q.out) | $past(wpins)));
    endproperty
    a_out_set: assert property (p_out_set) else $error("output set alias wrong"); // [RULE2]

    property p_out_clr;
        s_wr(lpio_pkg::OFF_OUT_CLR) |=> (q.out == ($past(q.out) & ~$past(wpins)));
    endproperty
    a_out_clr: assert property (p_out_clr) else $error("output clear alias wrong"); // [RULE3]

    property p_oe_set;
        s_wr(lpio_pkg::OFF_OE_SET) |=> (q.oe == ($past(q.oe) | $past(wpins)));
    endproperty
    a_oe_set: assert property (p_oe_set) else $error("enable set alias wrong"); // [RULE5]

    property p_oe_clr;
        s_wr(lpio_pkg::OFF_OE_CLR) |=> (q.oe == ($past(q.oe) & ~$past(wpins)));
    endproperty
    a_oe_clr: assert property (p_oe_clr) else $error("enable clear alias wrong"); // [RULE6]

    property p_pend_set;
        s_wr(lpio_pkg::OFF_PEND_SET) |=> ((q.pend & $past(wpins)) == $past(wpins));
    endproperty
    a_pend_set: assert property (p_pend_set) else $error("pending set alias wrong"); // [RULE8]

    property p_pend_clr;
        s_wr(lpio_pkg::OFF_PEND_CLR)
            |=> ((q.pend & $past(wpins)) == ($past(hit) & $past(wpins)));
    endproperty
    a_pend_clr: assert property (p_pend_clr) else $error("pending clear alias wrong"); // [RULE9]

    property p_hit_sets;
        (|hit) |=> ((q.pend & $past(hit)) == $past(hit));
    endproperty
    a_hit_sets: assert property (p_hit_sets) else $error("trigger lost"); // [RULE21]

    property p_drive_needs_enable;
        1'b1 |=> ((~pad_oe_n_o & $past(lp_dom) & ~$past(sleep_ovr)
                   & ~$past(q.oe) & ~$past(i2c_low)) == '0);
    endproperty
    a_drive_needs_enable: assert property (p_drive_needs_enable) // [RULE4]
        else $error("undriven pin driven");

    property p_read_input;
        (take && avs_req_i.read && avs_req_i.address == lpio_pkg::OFF_IN)
            |-> (avs_readdata_o[L +: N] == $past(pad_in_i)) && (avs_readdata_o[L-1:0] == '0);
    endproperty
    a_read_input: assert property (p_read_input) else $error("input readback wrong"); // [RULE10]

    sequence s_wait;
        req && avs_waitrequest_o;
    endsequence

    property p_bus_answer;
        s_wait ##1 req |-> !avs_waitrequest_o;
    endproperty
    a_bus_answer: assert property (p_bus_answer) else $error("bus answer late");

    property p_xtal;
        1'b1 |=> (xtal_powerdown_o == ($past(pad_in_i[q.xsel]) ^ $past(xtal_invert_i)));
    endproperty
    a_xtal: assert property (p_xtal) else $error("crystal power-down wrong"); // [RULE17]

endmodule

/* bench/lpio_pins_model.sv */
`timescale 1ns/1ps
// ----------------------------------------
// circuitry outside the low-power pins
// ----------------------------------------
module lpio_pins_model #(
    parameter int NP = 22
) (
    // clock
    input wire logic clk_sys_i,
    // port side
    input wire logic [NP-1:0] pad_out_i,
    input wire logic [NP-1:0] pad_oe_n_i,
    input wire logic [NP-1:0] pad_pullup_i,
    input wire logic [NP-1:0] pad_pulldown_i,
    // outside drivers
    input wire logic [NP-1:0] ext_level_i,
    input wire logic [NP-1:0] ext_drive_i,
    output logic [NP-1:0] pad_level_o
);
    // a floating pin wanders, so no test can lean on a stale level
    logic wander = 1'b0;
    always_ff @(posedge clk_sys_i) begin
        wander <= ~wander;
    end
    always_comb begin
        for (int k = 0; k < NP; k++) begin
            if (!pad_oe_n_i[k]) begin
                pad_level_o[k] = pad_out_i[k];
            end else if (ext_drive_i[k]) begin
                pad_level_o[k] = ext_level_i[k];
            end else if (pad_pullup_i[k]) begin
                pad_level_o[k] = 1'b1;
            end else if (pad_pulldown_i[k]) begin
                pad_level_o[k] = 1'b0;
            end else begin
                pad_level_o[k] = wander;
            end
        end
    end
endmodule

/* bench/test_lpio_port.sv */
`timescale 1ns/1ps
module test_lpio_port;
    localparam int NP = lpio_pkg::PINS;
    logic clk_sys_i, rst_n_i, sleep, lsleep, wake, xinv, xpd, scl_in, sda_in;
    lpio_pkg::lpio_avm_req_t req;
    logic [31:0] rdata, q;
    logic wait_req, scl_low, sda_low;
    logic [NP-1:0] pin, pout, oe_n, pu, pd, dout, doe, ext_lvl, ext_en, ie;
    logic [lpio_pkg::TOUCH_PADS-1:0] tie;
    int err_count, checked, c;

    lpio_port dut_u (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .avs_req_i(req),
        .avs_readdata_o(rdata), .avs_waitrequest_o(wait_req), .pad_in_i(pin),
        .pad_out_o(pout), .pad_oe_n_o(oe_n), .pad_ie_o(ie), .pad_pullup_o(pu),
        .pad_pulldown_o(pd), .touch_tie_o(tie), .dig_out_i(dout), .dig_oe_i(doe),
        .sleep_i(sleep), .light_sleep_i(lsleep), .wake_o(wake), .xtal_invert_i(xinv),
        .xtal_powerdown_o(xpd), .i2c_scl_drive_low_i(scl_low),
        .i2c_sda_drive_low_i(sda_low), .i2c_scl_in_o(scl_in), .i2c_sda_in_o(sda_in));
    lpio_pins_model #(.NP(NP)) pins_u (.clk_sys_i(clk_sys_i), .pad_out_i(pout),
        .pad_oe_n_i(oe_n), .pad_pullup_i(pu), .pad_pulldown_i(pd),
        .ext_level_i(ext_lvl), .ext_drive_i(ext_en), .pad_level_o(pin));

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one avalon transfer; request holds until waitrequest is low at a rising edge
    task automatic acc(input logic w, input logic [8:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys_i);
        req.read <= ~w;
        req.write <= w;
        req.address <= a;
        req.writedata <= d;
        @(posedge clk_sys_i);
        while (wait_req !== 1'b0 && n < 50) begin
            n++;
            @(posedge clk_sys_i);
        end
        if (n == 50) begin
            err_count++;
            close_out();
        end
        q = rdata;
        req.read <= 1'b0;
        req.write <= 1'b0;
    endtask
    task automatic wr(input logic [8:0] a, input logic [31:0] d);
        acc(1'b1, a, d);
    endtask
    task automatic rdc(input logic [8:0] a, input logic [31:0] exp);
        acc(1'b0, a, 32'h0);
        chk($sformatf("reg %h", a), exp, q);
    endtask
    task automatic settle();
        repeat (4) @(posedge clk_sys_i);
    endtask

    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    initial begin
        rst_n_i = 1'b0;
        req = '0;
        req.byteenable = 4'hf;
        {sleep, lsleep, xinv, scl_low, sda_low, dout, doe, ext_lvl} = '0;
        ext_en = '1;
        err_count = 0;
        checked = 0;
        repeat (20) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        // ---------------------------------
        // output, enable, open drain, sleep
        // ---------------------------------
        wr(lpio_pkg::OFF_PADCFG, 32'h0009_c000);
        wr(lpio_pkg::OFF_OUT_SET, 32'h0000_0400);
        rdc(lpio_pkg::OFF_OUT, 32'h0000_0400);
        wr(lpio_pkg::OFF_OUT_CLR, 32'h0000_0000);
        rdc(lpio_pkg::OFF_OUT, 32'h0000_0400);
        wr(lpio_pkg::OFF_OE_SET, 32'h0000_0400);
        rdc(lpio_pkg::OFF_IN, 32'h0000_0400);
        chk("oe_n0", 32'h0, oe_n[0]);
        wr(lpio_pkg::OFF_PINCFG, 32'h0000_0004);
        settle();
        chk("oe_n0", 32'h1, oe_n[0]);
        wr(lpio_pkg::OFF_OUT_CLR, 32'h0000_0400);
        rdc(lpio_pkg::OFF_OUT, 32'h0000_0000);
        chk("oe_n0", 32'h0, oe_n[0]);
        wr(lpio_pkg::OFF_OE_CLR, 32'h0000_0400);
        rdc(lpio_pkg::OFF_OE, 32'h0000_0000);
        chk("oe_n0", 32'h1, oe_n[0]);
        sleep <= 1'b1;
        settle();
        chk("oe_n0", 32'h0, oe_n[0]);
        chk("ie0", 32'h1, ie[0]);
        sleep <= 1'b0;
        wr(lpio_pkg::OFF_PADCFG, 32'h0000_0000);
        doe[0] <= 1'b1;
        dout[0] <= 1'b1;
        settle();
        chk("pout0", 32'h1, {oe_n[0], pout[0]} == 2'b01);
        doe[0] <= 1'b0;
        $display("test output done");
        // ---------------------------------
        // pending bits and trigger types
        // ---------------------------------
        wr(lpio_pkg::OFF_PEND, 32'h0000_0800);
        rdc(lpio_pkg::OFF_PEND, 32'h0000_0800);
        wr(lpio_pkg::OFF_PEND_SET, 32'h0000_1000);
        rdc(lpio_pkg::OFF_PEND, 32'h0000_1800);
        wr(lpio_pkg::OFF_PEND_CLR, 32'h0000_1800);
        rdc(lpio_pkg::OFF_PEND, 32'h0000_0000);
        lsleep <= 1'b1;
        for (c = 0; c < 6; c++) begin
            wr(lpio_pkg::OFF_PINCFG + 9'h010, (c << 7) | 32'h400);
            wr(lpio_pkg::OFF_PEND_CLR, 32'h0000_4000);
            rdc(lpio_pkg::OFF_PEND, (c == 4) ? 32'h4000 : 32'h0);
            ext_lvl[4] <= 1'b1;
            rdc(lpio_pkg::OFF_PEND, (c inside {1, 3, 4, 5}) ? 32'h4000 : 32'h0);
            chk("wake", (c == 5), wake);
            wr(lpio_pkg::OFF_PEND_CLR, 32'h0000_4000);
            ext_lvl[4] <= 1'b0;
            rdc(lpio_pkg::OFF_PEND, (c inside {2, 3, 4, 5}) ? 32'h4000 : 32'h0);
        end
        wr(lpio_pkg::OFF_PINCFG + 9'h010, 32'h0);
        $display("test pending done");
        // ---------------------------------
        // pulls, tie, crystal, i2c, unmapped
        // ---------------------------------
        ext_en[1] <= 1'b0;
        wr(lpio_pkg::OFF_PADCFG + 9'h004, 32'h1080_0000);
        rdc(lpio_pkg::OFF_IN, 32'h0000_0800);
        chk("tie1", 32'h1, tie[1]);
        wr(lpio_pkg::OFF_PADCFG + 9'h004, 32'h0800_0000);
        rdc(lpio_pkg::OFF_IN, 32'h0000_0000);
        wr(lpio_pkg::OFF_XTL, 32'h2800_0000);
        ext_lvl[5] <= 1'b1;
        settle();
        chk("xpd", 32'h1, xpd);
        xinv <= 1'b1;
        settle();
        chk("xpd", 32'h0, xpd);
        wr(lpio_pkg::OFF_I2C, 32'h0000_0003);
        ext_lvl[3:2] <= 2'b11;
        settle();
        chk("i2c", 32'h3, {sda_in, scl_in});
        wr(lpio_pkg::OFF_PADCFG + 9'h008, 32'h0008_0000);
        {scl_low, sda_low} <= 2'b11;
        settle();
        chk("i2c low", 32'h14, {sda_in, scl_in, oe_n[3], oe_n[2], pout[2]});
        {scl_low, sda_low} <= 2'b00;
        wr(lpio_pkg::OFF_I2C, 32'h0000_0000);
        settle();
        chk("i2c", 32'h0, {sda_in, scl_in});
        rdc(9'h100, 32'h0);
        $display("test pads done");
        close_out();
    end
endmodule
